// File: common/fsl_pkg.sv
// Purpose: shared constants for the field-side serial latch port
// Assumes: system clock 100 MHz, link clock from the isolated host
// Notes: frame layout, mode codes, power-up delay and state codes
package fsl_pkg;

  localparam int INPUT_W = 8;
  localparam int FAULT_W = 6;
  localparam int FRAME_W = 16;
  localparam int HALF_W = FRAME_W / 2;
  localparam int PAD_W = FRAME_W - INPUT_W - FAULT_W;

  // fault flag positions inside the fault vector
  localparam int FLT_SUPPLY_LOW = 0;
  localparam int FLT_SUPPLY_MISS = 1;
  localparam int FLT_TEMP = 2;
  localparam int FLT_CRC = 3;
  localparam int FLT_WIRE_BREAK = 4;
  localparam int FLT_REF_PIN = 5;

  // synchroniser bus layout
  localparam int SY_CS = 0;
  localparam int SY_LATCH = 1;
  localparam int SY_POWER = 2;
  localparam int SY_FAULT_ISOLATION_INPUT_N = 3;
  localparam int SY_READY_ISOLATION_INPUT_N = 4;
  localparam int SY_MODE_LO = 5;
  localparam int SY_MODE_HI = 6;
  localparam int SY_SDO = 7;
  localparam int SY_IN_LSB = 8;
  localparam int SY_FLT_LSB = SY_IN_LSB + INPUT_W;
  localparam int SY_W = SY_FLT_LSB + FAULT_W;

  // power-up settling time
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int POWER_DELAY_US = 100;
  localparam int POWER_DELAY_CYCLES =
    (POWER_DELAY_US * 1000) / CLOCK_PERIOD_NS;
  localparam int DELAY_CNT_W = 16;

  // serial framing modes: bit 1 long frame, bit 0 lsb first
  typedef enum logic [1:0] {
    FSL_MODE_MSB8 = 2'h0,
    FSL_MODE_LSB8 = 2'h1,
    FSL_MODE_LSB16 = 2'h3,
    FSL_MODE_MSB16 = 2'h2
  } fsl_mode_e;

  // field power state, gray along off, settle, ready
  typedef enum logic [1:0] {
    FSL_PWR_OFF = 2'h0,
    FSL_PWR_SETTLE = 2'h1,
    FSL_PWR_READY = 2'h3
  } fsl_pwr_e;

  localparam logic [INPUT_W-1:0] INPUT_RESET = 8'h00;
  localparam logic [FAULT_W-1:0] FAULT_RESET = 6'h00;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 16'h0000;
  localparam logic [HALF_W-1:0] HALF_ZERO = 8'h00;
  localparam logic [PAD_W-1:0] PAD_ZERO = 2'h0;

endpackage

// File: src/fsl_sync.sv
// Purpose: two flip-flop synchroniser for a bus of unrelated levels
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module fsl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= IDLE;
      stage2_reg <= IDLE;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule
`default_nettype wire

// File: src/fsl_delay.sv
// Purpose: settle timer, done after CYCLES clocks of run held high
// Assumes: run is synchronous to clock
// Notes: dropping run restarts the count
`timescale 1ns/1ps
`default_nettype none
module fsl_delay #(
  parameter int CYCLES = fsl_pkg::POWER_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  output logic done
);

  localparam logic [fsl_pkg::DELAY_CNT_W-1:0] LAST =
    fsl_pkg::DELAY_CNT_W'(CYCLES - 1);
  localparam logic [fsl_pkg::DELAY_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [fsl_pkg::DELAY_CNT_W-1:0] CNT_ONE =
    fsl_pkg::DELAY_CNT_W'(1);

  logic [fsl_pkg::DELAY_CNT_W-1:0] cnt_reg;
  logic done_reg;
  wire at_end = (cnt_reg == LAST);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= CNT_ZERO;
      done_reg <= 1'b0;
    end else if (!run) begin
      cnt_reg <= CNT_ZERO;
      done_reg <= 1'b0;
    end else if (!done_reg) begin
      cnt_reg <= cnt_reg + CNT_ONE;
      done_reg <= at_end;
    end
  end

  assign done = done_reg;

endmodule
`default_nettype wire

// File: src/fsl_port.sv
// Purpose: field-side serial port, input latch, fault and ready logic
// Assumes: link clock comes from the host and may stop between frames
// Notes: link logic is reset while the chip select is high
//
// Function
// (R1) sample serial input on each rising link clock edge while selected
// (R2) serial output changes only on falling link clock edges; the code also clears it to 0 when chip select goes high
// (R3) serial output released whenever chip select is high
// (R4) input latch transparent only while chip select and strobe both high
// (R5) freeze inputs when either chip select or strobe falls, hold while low
// (R6) drive fault indicator low whenever any fault flag is set
// (R7) pull ready indicator low once field side is powered, else release
// (R8) ready input high: active flag low, host fault and data low
// (R9) ready input low: active flag high, channels pass normally
// (R10) last in daisy chain: serial input data follows own frame out
// (R11) host chip select low latches inputs and enables the serial port
// (R12) raise active flag only after the power settling delay
// (R13) host latch strobe low freezes inputs without selecting the port
// (R14) mode pins sampled while idle choose frame length and bit order
`timescale 1ns/1ps
`default_nettype none
module fsl_port #(
  parameter int POWER_DELAY_CYCLES = fsl_pkg::POWER_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic field_serial_clock,
  input wire logic field_serial_in,
  input wire logic field_chip_select_n,
  input wire logic field_latch_strobe_n,
  input wire logic [fsl_pkg::INPUT_W-1:0] field_inputs,
  input wire logic [fsl_pkg::FAULT_W-1:0] fault_flags,
  input wire logic field_power_good,
  input wire logic fault_isolation_input_n,
  input wire logic ready_isolation_input_n,
  input wire logic serial_mode_bit_high,
  input wire logic serial_mode_bit_low,
  output logic field_serial_out,
  output logic field_serial_out_oe,
  output logic field_fault_indicator_n,
  output logic field_fault_indicator_oe,
  output logic ready_indicator_out_n,
  output logic ready_indicator_out_oe,
  output logic field_active_flag,
  output logic host_fault_output_n,
  output logic host_fault_output_oe,
  output logic host_serial_out
);

  // system domain: synchronised pins
  logic [fsl_pkg::SY_W-1:0] sy_in;
  logic [fsl_pkg::SY_W-1:0] sy;
  logic sdo_link_reg;

  // idle levels of the active-low pins, so reset shows no false select
  localparam logic [fsl_pkg::SY_W-1:0] SY_IDLE =
    (fsl_pkg::SY_W'(1'h1) << fsl_pkg::SY_CS) |
    (fsl_pkg::SY_W'(1'h1) << fsl_pkg::SY_LATCH) |
    (fsl_pkg::SY_W'(1'h1) << fsl_pkg::SY_FAULT_ISOLATION_INPUT_N) |
    (fsl_pkg::SY_W'(1'h1) << fsl_pkg::SY_READY_ISOLATION_INPUT_N);

  assign sy_in[fsl_pkg::SY_CS] = field_chip_select_n;
  assign sy_in[fsl_pkg::SY_LATCH] = field_latch_strobe_n;
  assign sy_in[fsl_pkg::SY_POWER] = field_power_good;
  assign sy_in[fsl_pkg::SY_FAULT_ISOLATION_INPUT_N] = fault_isolation_input_n;
  assign sy_in[fsl_pkg::SY_READY_ISOLATION_INPUT_N] = ready_isolation_input_n;
  assign sy_in[fsl_pkg::SY_MODE_LO] = serial_mode_bit_low;
  assign sy_in[fsl_pkg::SY_MODE_HI] = serial_mode_bit_high;
  assign sy_in[fsl_pkg::SY_SDO] = sdo_link_reg;
  assign sy_in[fsl_pkg::SY_FLT_LSB-1:fsl_pkg::SY_IN_LSB] = field_inputs;
  assign sy_in[fsl_pkg::SY_W-1:fsl_pkg::SY_FLT_LSB] = fault_flags;

  fsl_sync #(
    .W(fsl_pkg::SY_W),
    .IDLE(SY_IDLE)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in(sy_in),
    .sync_out(sy)
  );

  wire cs_n_s = sy[fsl_pkg::SY_CS];
  wire latch_n_s = sy[fsl_pkg::SY_LATCH];
  wire power_s = sy[fsl_pkg::SY_POWER];
  wire fault_isolation_input_n_n_s = sy[fsl_pkg::SY_FAULT_ISOLATION_INPUT_N];
  wire ready_isolation_input_n_n_s = sy[fsl_pkg::SY_READY_ISOLATION_INPUT_N];
  wire sdo_s = sy[fsl_pkg::SY_SDO];
  wire [1:0] mode_pins_s = {sy[fsl_pkg::SY_MODE_HI],
                            sy[fsl_pkg::SY_MODE_LO]};
  wire [fsl_pkg::INPUT_W-1:0] inputs_s =
    sy[fsl_pkg::SY_FLT_LSB-1:fsl_pkg::SY_IN_LSB];
  wire [fsl_pkg::FAULT_W-1:0] faults_s =
    sy[fsl_pkg::SY_W-1:fsl_pkg::SY_FLT_LSB];

  // input latch in front of the serializer
  logic [fsl_pkg::INPUT_W-1:0] held_in_reg;
  logic [fsl_pkg::FAULT_W-1:0] held_flt_reg;
  wire latch_open = cs_n_s & latch_n_s; // R4 R5

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      held_in_reg <= fsl_pkg::INPUT_RESET;
      held_flt_reg <= fsl_pkg::FAULT_RESET;
    end else if (latch_open) begin // R4 R11 R13
      held_in_reg <= inputs_s;
      held_flt_reg <= faults_s;
    end
  end
  // a falling select or strobe closes the latch; held while low

  // framing mode, only taken while the port is idle
  fsl_pkg::fsl_mode_e mode_reg;
  wire mode_long = mode_reg[1];
  wire mode_lsb = mode_reg[0];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= fsl_pkg::FSL_MODE_MSB8;
    end else if (cs_n_s) begin // R14
      mode_reg <= fsl_pkg::fsl_mode_e'(mode_pins_s);
    end
  end

  // frame word, first bit at the top
  logic [fsl_pkg::INPUT_W-1:0] in_ordered;
  logic [fsl_pkg::FAULT_W-1:0] flt_ordered;

  genvar gi;
  generate
    for (gi = 0; gi < fsl_pkg::INPUT_W; gi = gi + 1) begin : g_in
      assign in_ordered[gi] = mode_lsb ?
        held_in_reg[fsl_pkg::INPUT_W-1-gi] : held_in_reg[gi];
    end
    for (gi = 0; gi < fsl_pkg::FAULT_W; gi = gi + 1) begin : g_flt
      assign flt_ordered[gi] = mode_lsb ?
        held_flt_reg[fsl_pkg::FAULT_W-1-gi] : held_flt_reg[gi];
    end
  endgenerate

  wire [fsl_pkg::FRAME_W-1:0] frame_long =
    {in_ordered, fsl_pkg::PAD_ZERO, flt_ordered};
  wire [fsl_pkg::FRAME_W-1:0] frame_short =
    {in_ordered, fsl_pkg::HALF_ZERO};
  // quasi-static: held by the latch for the whole selected frame
  wire [fsl_pkg::FRAME_W-1:0] frame_word =
    mode_long ? frame_long : frame_short;

  // link domain: serial shifter on the host clock
  wire link_rst_n = nrst & ~field_chip_select_n;
  logic sdi_cap_reg;
  logic loaded_reg;
  logic [fsl_pkg::FRAME_W-1:0] shift_reg;

  always_ff @(posedge field_serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdi_cap_reg <= 1'b0;
    end else begin
      sdi_cap_reg <= field_serial_in; // R1
    end
  end

  wire [fsl_pkg::FRAME_W-1:0] shift_src =
    loaded_reg ? shift_reg : frame_word;
  wire [fsl_pkg::FRAME_W-1:0] shift_long =
    {shift_src[fsl_pkg::FRAME_W-2:0], sdi_cap_reg};
  wire [fsl_pkg::FRAME_W-1:0] shift_short =
    {shift_src[fsl_pkg::FRAME_W-2:fsl_pkg::HALF_W], sdi_cap_reg,
     fsl_pkg::HALF_ZERO};
  // chain data enters right behind this device's own bits
  wire [fsl_pkg::FRAME_W-1:0] shift_next =
    mode_long ? shift_long : shift_short; // R10

  always_ff @(negedge field_serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_link_reg <= 1'b0;
      loaded_reg <= 1'b0;
      shift_reg <= fsl_pkg::FRAME_RESET;
    end else begin
      sdo_link_reg <= shift_src[fsl_pkg::FRAME_W-1]; // R2
      loaded_reg <= 1'b1;
      shift_reg <= shift_next;
    end
  end

  assign field_serial_out = sdo_link_reg;

  // serial output enable follows the chip select
  logic sdo_oe_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= ~cs_n_s; // R3
    end
  end

  assign field_serial_out_oe = sdo_oe_reg;

  // field fault indicator, open drain
  logic fault_oe_reg;
  logic fault_n_reg;
  wire any_fault = |faults_s;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_oe_reg <= 1'b0;
      fault_n_reg <= 1'b1;
    end else begin
      fault_oe_reg <= any_fault; // R6
      fault_n_reg <= ~any_fault; // R6
    end
  end

  assign field_fault_indicator_n = fault_n_reg;
  assign field_fault_indicator_oe = fault_oe_reg;

  // field power sequencing
  fsl_pkg::fsl_pwr_e pwr_reg;
  fsl_pkg::fsl_pwr_e pwr_next;
  logic settle_done;

  fsl_delay #(
    .CYCLES(POWER_DELAY_CYCLES)
  ) u_delay (
    .clock(clock),
    .nrst(nrst),
    .run(power_s),
    .done(settle_done)
  );

  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      fsl_pkg::FSL_PWR_OFF: begin
        if (power_s) pwr_next = fsl_pkg::FSL_PWR_SETTLE;
      end
      fsl_pkg::FSL_PWR_SETTLE: begin
        if (!power_s) pwr_next = fsl_pkg::FSL_PWR_OFF;
        else if (settle_done) pwr_next = fsl_pkg::FSL_PWR_READY; // R12
      end
      fsl_pkg::FSL_PWR_READY: begin
        if (!power_s) pwr_next = fsl_pkg::FSL_PWR_OFF;
      end
      default: pwr_next = fsl_pkg::FSL_PWR_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwr_reg <= fsl_pkg::FSL_PWR_OFF;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  wire field_ready = (pwr_reg == fsl_pkg::FSL_PWR_READY);
  wire power_up = (pwr_reg != fsl_pkg::FSL_PWR_OFF);

  // ready indicator, open drain
  logic ready_oe_reg;
  logic ready_n_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ready_oe_reg <= 1'b0;
      ready_n_reg <= 1'b1;
    end else begin
      ready_oe_reg <= power_up; // R7
      ready_n_reg <= ~power_up; // R7
    end
  end

  assign ready_indicator_out_n = ready_n_reg;
  assign ready_indicator_out_oe = ready_oe_reg;

  // isolation channel outputs toward the host
  wire channels_ok = ~ready_isolation_input_n_n_s;
  wire afs_next = channels_ok & field_ready; // R9 R12
  wire hfault_drive = channels_ok ? ~fault_isolation_input_n_n_s : 1'b1; // R8
  wire hsdo_next = channels_ok ? sdo_s : 1'b0; // R8
  logic afs_reg;
  logic hfault_oe_reg;
  logic hfault_n_reg;
  logic hsdo_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      afs_reg <= 1'b0;
      hfault_oe_reg <= 1'b1;
      hfault_n_reg <= 1'b0;
      hsdo_reg <= 1'b0;
    end else begin
      afs_reg <= afs_next;
      hfault_oe_reg <= hfault_drive;
      hfault_n_reg <= ~hfault_drive;
      hsdo_reg <= hsdo_next;
    end
  end

  assign field_active_flag = afs_reg;
  assign host_fault_output_n = hfault_n_reg;
  assign host_fault_output_oe = hfault_oe_reg;
  assign host_serial_out = hsdo_reg;

endmodule
`default_nettype wire

// File: test/fsl_port_sva.sv
// Purpose: checker for fsl_port
// Assumes: bound to every fsl_port
// Notes: all checks in the system clock domain
`timescale 1ns/1ps
`default_nettype none
module fsl_port_sva #(
  parameter int POWER_DELAY_CYCLES = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic field_serial_clock,
  input wire logic field_chip_select_n,
  input wire logic field_latch_strobe_n,
  input wire logic [fsl_pkg::FAULT_W-1:0] fault_flags,
  input wire logic field_power_good,
  input wire logic fault_isolation_input_n,
  input wire logic ready_isolation_input_n,
  input wire logic field_serial_out,
  input wire logic field_serial_out_oe,
  input wire logic field_fault_indicator_oe,
  input wire logic ready_indicator_out_oe,
  input wire logic field_active_flag,
  input wire logic host_fault_output_oe,
  input wire logic host_serial_out
);
  int pwr_cnt_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) pwr_cnt_reg <= 0;
    else if (!field_power_good) pwr_cnt_reg <= 0;
    else if (pwr_cnt_reg < 99999) pwr_cnt_reg <= pwr_cnt_reg + 1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence transp_s;
    (field_chip_select_n && field_latch_strobe_n && $stable(fault_flags))[*6];
  endsequence
  sequence ready_low_s;
    (!ready_isolation_input_n && pwr_cnt_reg > POWER_DELAY_CYCLES + 10)[*6];
  endsequence
  a_out_fall_only: assert property (
    $changed(field_serial_out) |-> !field_serial_clock)
    else $error("serial out moved while link clock high");
  a_oe_released: assert property (
    field_chip_select_n[*5] |-> !field_serial_out_oe)
    else $error("serial out driven while deselected");
  a_oe_selected: assert property (
    !field_chip_select_n[*5] |-> field_serial_out_oe)
    else $error("serial out not driven while selected");
  a_fault_follows: assert property (
    transp_s |-> field_fault_indicator_oe == (|fault_flags))
    else $error("fault indicator disagrees with flags");
  a_ready_power: assert property (
    $stable(field_power_good)[*6] |->
      ready_indicator_out_oe == field_power_good)
    else $error("ready indicator disagrees with power");
  a_active_delay: assert property (
    $rose(field_active_flag) |-> pwr_cnt_reg >= POWER_DELAY_CYCLES)
    else $error("active flag rose before settling delay");
  a_active_on: assert property (
    ready_low_s |-> field_active_flag)
    else $error("active flag low while ready");
  a_not_ready: assert property (
    ready_isolation_input_n[*5] |->
      !field_active_flag && host_fault_output_oe && !host_serial_out)
    else $error("host outputs not defaulted while not ready");
  a_host_fault: assert property (
    (!ready_isolation_input_n && $stable(fault_isolation_input_n))[*5] |->
      host_fault_output_oe == !fault_isolation_input_n)
    else $error("host fault does not follow fault channel");
endmodule
bind fsl_port fsl_port_sva #(.POWER_DELAY_CYCLES(POWER_DELAY_CYCLES))
  fsl_port_sva_i (.clock(clock), .nrst(nrst),
  .field_serial_clock(field_serial_clock),
  .field_chip_select_n(field_chip_select_n),
  .field_latch_strobe_n(field_latch_strobe_n), .fault_flags(fault_flags),
  .field_power_good(field_power_good),
  .fault_isolation_input_n(fault_isolation_input_n),
  .ready_isolation_input_n(ready_isolation_input_n),
  .field_serial_out(field_serial_out),
  .field_serial_out_oe(field_serial_out_oe),
  .field_fault_indicator_oe(field_fault_indicator_oe),
  .ready_indicator_out_oe(ready_indicator_out_oe),
  .field_active_flag(field_active_flag),
  .host_fault_output_oe(host_fault_output_oe),
  .host_serial_out(host_serial_out));
`default_nettype wire

// File: test/fsl_host_model.sv
// Purpose: host master driving the link across the isolation
// Assumes: link clock idles low and stops between frames
// Notes: preceding chain slave is folded into the serial input
`timescale 1ns/1ps
`default_nettype none
module fsl_host_model (
  output logic field_serial_clock,
  output logic field_chip_select_n,
  output logic field_serial_in,
  input wire logic field_serial_out,
  output logic [31:0] cap
);
  initial begin
    field_serial_clock = 1'b0;
    field_chip_select_n = 1'b1;
    field_serial_in = 1'b0;
    cap = 32'h0;
  end
  task automatic frame(input int len, input logic [7:0] chain);
    cap = 32'h0;
    field_chip_select_n = 1'b0;
    #73;
    for (int i = 1; i <= len + 9; i++) begin
      field_serial_in = (i <= 8) ? chain[8 - i] : ~field_serial_in;
      #24 field_serial_clock = 1'b1;
      cap = {cap[30:0], field_serial_out};
      #24 field_serial_clock = 1'b0;
    end
    #30 field_chip_select_n = 1'b1;
    field_serial_in = ~field_serial_in;
    #70;
  endtask
endmodule
`default_nettype wire

// File: test/fsl_port_bench.sv
// Purpose: self-checking bench for fsl_port
// Assumes: open-drain lines pulled up, ready and fault looped back
// Notes: power settling shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module fsl_port_bench;
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] din;
    logic [5:0] flt;
    logic [7:0] chain;
    logic [15:0] frame;
  } fsl_row_s;
  localparam fsl_row_s ROWS [4] = '{
    '{2'h0, 8'hC1, 6'h00, 8'h5A, 16'h00C1},
    '{2'h1, 8'hC1, 6'h00, 8'hA7, 16'h0083},
    '{2'h2, 8'h3C, 6'h05, 8'h31, 16'h3C05},
    '{2'h3, 8'h3C, 6'h05, 8'hE2, 16'h3C28}};
  logic clock, nrst, strobe_n, power_good, mode_hi, mode_lo, block_ready;
  logic [7:0] din;
  logic [5:0] flt;
  wire logic sclk, cs_n, sdi, sdo, sdo_oe, field_fault_indicator_n_oe, rdy_oe;
  wire logic active, hfault_oe, hsdo;
  wire logic [31:0] cap;
  wire logic rdy_iso_n = ~rdy_oe | block_ready;
  wire logic flt_iso_n = ~field_fault_indicator_n_oe;
  // released serial line shows the inverse, so a late enable is seen
  wire logic sdo_line = sdo_oe ? sdo : ~sdo;
  int bad_count = 0;
  int num_checks = 0;
  fsl_port #(.POWER_DELAY_CYCLES(20)) fsl_port_i (.clock(clock),
    .nrst(nrst), .field_serial_clock(sclk), .field_serial_in(sdi),
    .field_chip_select_n(cs_n), .field_latch_strobe_n(strobe_n),
    .field_inputs(din), .fault_flags(flt), .field_power_good(power_good),
    .fault_isolation_input_n(flt_iso_n), .ready_isolation_input_n(rdy_iso_n),
    .serial_mode_bit_high(mode_hi), .serial_mode_bit_low(mode_lo),
    .field_serial_out(sdo), .field_serial_out_oe(sdo_oe),
    .field_fault_indicator_n(), .field_fault_indicator_oe(field_fault_indicator_n_oe),
    .ready_indicator_out_n(), .ready_indicator_out_oe(rdy_oe),
    .field_active_flag(active), .host_fault_output_n(),
    .host_fault_output_oe(hfault_oe), .host_serial_out(hsdo));
  fsl_host_model fsl_host_model_i (.field_serial_clock(sclk),
    .field_chip_select_n(cs_n), .field_serial_in(sdi),
    .field_serial_out(sdo_line), .cap(cap));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic frame(input int len, input logic [7:0] c,
                       input logic [15:0] e);
    logic [31:0] mask;
    mask = (32'h1 << (len + 8)) - 32'h1;
    fsl_host_model_i.frame(len, c);
    check(cap & mask, ({16'h0, e} << 8) | c);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    nrst = 1'b0;
    strobe_n = 1'b1;
    power_good = 1'b0;
    mode_hi = 1'b0;
    mode_lo = 1'b0;
    block_ready = 1'b0;
    din = 8'h00;
    flt = 6'h00;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    cyc(6);
    check(rdy_oe, 0);
    check(active, 0);
    @(posedge clock) power_good <= 1'b1;
    cyc(8);
    check(rdy_oe, 1);
    cyc(10);
    check(active, 0);
    cyc(20);
    check(active, 1);
    $display("power-up test done");
    foreach (ROWS[i]) begin
      @(posedge clock);
      {mode_hi, mode_lo} <= ROWS[i].mode;
      din <= ROWS[i].din;
      flt <= ROWS[i].flt;
      cyc(8);
      frame(ROWS[i].mode[1] ? 16 : 8, ROWS[i].chain, ROWS[i].frame);
      check(field_fault_indicator_n_oe, ROWS[i].flt != 0);
      check(hfault_oe, ROWS[i].flt != 0);
      check(sdo_oe, 0);
      $display("row %0d done", i);
    end
    @(posedge clock);
    {mode_hi, mode_lo} <= 2'h0;
    din <= 8'h96;
    flt <= 6'h00;
    cyc(8);
    @(posedge clock) strobe_n <= 1'b0;
    cyc(6);
    @(posedge clock) din <= 8'h69;
    cyc(8);
    frame(8, 8'h0F, 16'h0096);
    @(posedge clock) strobe_n <= 1'b1;
    cyc(8);
    frame(8, 8'hF0, 16'h0069);
    $display("latch test done");
    @(posedge clock) block_ready <= 1'b1;
    cyc(6);
    fsl_host_model_i.frame(8, 8'hFF);
    check(active, 0);
    check(hfault_oe, 1);
    check(hsdo, 0);
    @(posedge clock) block_ready <= 1'b0;
    cyc(10);
    check(active, 1);
    @(posedge clock) power_good <= 1'b0;
    cyc(8);
    check(rdy_oe, 0);
    check(active, 0);
    $display("ready test done");
    @(posedge clock) nrst <= 1'b0;
    cyc(2);
    check(hfault_oe, 1);
    check(sdo_oe, 0);
    @(posedge clock) nrst <= 1'b1;
    cyc(1);
    check(sdo_oe, 0);
    check(hfault_oe, 1);
    cyc(1);
    check(sdo_oe, 0);
    check(active, 0);
    cyc(6);
    frame(8, 8'hA5, 16'h0069);
    $display("reset test done");
    stop_test();
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
